// ===== design/ebs_consts.vh
// Constants for the external bus sizing and termination block
// Behaviour
// - Two active-low byte write enables on writes
// - Enables decoded from strobe, offset bit, size
// - Transfer complete on last clock, normal end
// - No completion strobe on normal error or retry
// - Read acknowledge latches data and ends cycle
// - Ack pair: wait, byte, word, reserved word
// - Early external ack ends programmed-delay cycle
// - Fast termination ends access in two clocks
// - Bus fault ends cycle, with or without ack
// - Fault plus halt means retry termination
// - Internal monitor faults only own-master cycles
// - Autovector ends only interrupt acknowledge cycles
// - Start assuming wide port, adjust after ack
// - Long read: two wide or four narrow cycles
// - Size code shows bytes remaining in operand
// - Address holds word base plus byte offset
// - Wide read lanes: msb high, odd byte low
// - Long from narrow port starts size 00, even
// - Unrequested read lanes ignored; three-byte cycle
// - Size code 01 byte 10 word 11 three 00 long
// - Partial transfer lowers count, advances, repeats
`ifndef EBS_CONSTS_VH
`define EBS_CONSTS_VH
`define EBS_SIZE_BYTE 2'h1
`define EBS_SIZE_WORD 2'h2
`define EBS_SIZE_THREE 2'h3
`define EBS_SIZE_LONG 2'h0
`define EBS_END_NONE 3'h0
`define EBS_END_NORMAL 3'h1
`define EBS_END_FAULT 3'h2
`define EBS_END_RETRY 3'h3
`define EBS_END_LATE_FAULT 3'h4
`define EBS_END_LATE_RETRY 3'h5
`define EBS_END_AUTOVEC 3'h6
`define EBS_FAST_CYCLES 4'h2
`define EBS_MON_CYCLES 8'h40
`endif

// ===== design/ebs_sync2.v
// Two-stage synchroniser for pin inputs
`default_nettype none
module ebs_sync2 #(
    parameter W = 1
) (
    input wire clk_i,
    input wire nrst_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
        end
    end
    assign q_o = s2_reg;
endmodule // ebs_sync2
`default_nettype wire

// ===== design/ebs_term_decode.v
// Decodes cycle-termination inputs into one termination code
`include "ebs_consts.vh"
`default_nettype none
module ebs_term_decode (
    // Synchronised pins plus internal ack and cycle type, active high
    input wire wide_ack_i,
    input wire narrow_ack_i,
    input wire fault_i,
    input wire halt_i,
    input wire late_i,
    input wire autovec_i,
    input wire iack_cycle_i,
    input wire internal_ack_i,
    // Result
    output reg [2:0] code_o,
    output reg port_wide_o
);
    always @* begin
        port_wide_o = wide_ack_i;
        code_o = `EBS_END_NONE;
        if (fault_i && halt_i) begin
            code_o = late_i ? `EBS_END_LATE_RETRY : `EBS_END_RETRY;
        end else if (fault_i) begin
            code_o = late_i ? `EBS_END_LATE_FAULT : `EBS_END_FAULT;
        end else if (autovec_i && iack_cycle_i) begin
            code_o = `EBS_END_AUTOVEC;
        end else if (wide_ack_i || narrow_ack_i || internal_ack_i) begin
            code_o = `EBS_END_NORMAL;
        end
    end
endmodule // ebs_term_decode
`default_nettype wire

// ===== design/ebs_bus_master.v
// Bus master: dynamic sizing, byte enables, termination handling
`include "ebs_consts.vh"
`default_nettype none
module ebs_bus_master #(
    parameter MON_CYCLES = `EBS_MON_CYCLES
) (
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Operand request from the core
    input wire req_i,
    input wire req_write_i,
    input wire [1:0] req_size_i,
    input wire [31:0] req_addr_i,
    input wire [31:0] req_wdata_i,
    input wire req_iack_i,
    input wire req_legacy_i,
    input wire req_ext_master_i,
    // Chip-select configuration
    input wire cfg_internal_ack_i,
    input wire [3:0] cfg_ack_delay_i,
    input wire cfg_fast_term_i,
    // Operand completion
    output reg done_o,
    output reg fault_o,
    output reg retry_o,
    output reg autovec_o,
    output reg [31:0] rdata_o,
    output reg busy_o,
    // Bus pins, termination inputs asynchronous, active low except late_term_i (active high)
    input wire wide_port_ack_n_i,
    input wire narrow_port_ack_n_i,
    input wire bus_fault_input_n_i,
    input wire halt_n_i,
    input wire auto_vector_input_n_i,
    input wire late_term_i,
    input wire [15:0] data_i,
    output reg [31:0] addr_o,
    output reg size_code_high_o,
    output reg size_code_low_o,
    output reg read_write_o,
    output reg native_data_strobe_n_o,
    output reg legacy_upper_byte_strobe_n_o,
    output reg legacy_lower_byte_strobe_n_o,
    output reg upper_byte_write_strobe_n_o,
    output reg lower_byte_write_strobe_n_o,
    output reg transfer_complete_strobe_n_o,
    output reg [15:0] data_o,
    output reg data_oe_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_NEXT = 2'h3;

    // Bytes left for a size code; long word encodes as four
    function [2:0] bytes_of;
        input [1:0] code;
        begin
            bytes_of = (code == `EBS_SIZE_LONG) ? 3'h4 : {1'b0, code};
        end
    endfunction

    // Byte of the operand at position idx (0 = most significant)
    function [7:0] op_byte;
        input [31:0] op;
        input [2:0] total;
        input [2:0] idx;
        reg [2:0] sh;
        begin
            sh = total - idx - 3'h1;
            op_byte = op[{sh[1:0], 3'h0} +: 8];
        end
    endfunction

    // Low lanes carry data: odd byte, or more than one byte left
    function lower_lane;
        input a0;
        input [2:0] left_cnt;
        begin
            lower_lane = a0 || left_cnt != 3'h1;
        end
    endfunction

    wire [4:0] pins_n;
    wire [4:0] pins_s;
    assign pins_n = {wide_port_ack_n_i, narrow_port_ack_n_i,
        bus_fault_input_n_i, halt_n_i, auto_vector_input_n_i};
    // Pins are inverted here so the decoder sees active-high levels
    ebs_sync2 #(.W(5)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(~pins_n),
        .q_o(pins_s)
    );
    // Late flag takes the same two stages so it lines up with the acks
    wire late_s;
    ebs_sync2 #(.W(1)) u_sync_late (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(late_term_i),
        .q_o(late_s)
    );

    reg [1:0] state_reg;
    reg [1:0] size_reg;
    reg [2:0] total_reg;
    reg [31:0] op_reg;
    reg write_reg;
    reg iack_reg;
    reg legacy_reg;
    reg extm_reg;
    reg [3:0] wait_reg;
    reg [7:0] mon_reg;

    wire int_ack;
    wire mon_fault;
    wire [2:0] code;
    wire wide;
    // Programmed delay or fast termination; external ack may beat it
    assign int_ack = (cfg_fast_term_i && wait_reg >= `EBS_FAST_CYCLES - 4'h1)
        || (cfg_internal_ack_i && wait_reg >= cfg_ack_delay_i);
    // Monitor only covers cycles this device masters
    assign mon_fault = !extm_reg && mon_reg == MON_CYCLES;

    ebs_term_decode u_dec (
        .wide_ack_i(pins_s[4]),
        .narrow_ack_i(pins_s[3]),
        .fault_i(pins_s[2] | mon_fault),
        .halt_i(pins_s[1]),
        .late_i(late_s),
        .autovec_i(pins_s[0]),
        .iack_cycle_i(iack_reg),
        .internal_ack_i(int_ack),
        .code_o(code),
        .port_wide_o(wide)
    );

    wire [2:0] left = bytes_of(size_reg);
    wire [2:0] idx = total_reg - left;
    // Narrow port moves one byte; wide port moves up to a word
    wire [2:0] moved = (!wide || addr_o[0] || left == 3'h1 ||
        int_ack && !pins_s[4] && !pins_s[3] && left == 3'h3)
        ? 3'h1 : 3'h2;
    wire [2:0] left_next = left - moved;
    wire ends = code != `EBS_END_NONE;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            size_reg <= `EBS_SIZE_LONG;
            total_reg <= 3'h0;
            op_reg <= 32'h0;
            write_reg <= 1'b0;
            iack_reg <= 1'b0;
            legacy_reg <= 1'b0;
            extm_reg <= 1'b0;
            wait_reg <= 4'h0;
            mon_reg <= 8'h0;
            done_o <= 1'b0;
            fault_o <= 1'b0;
            retry_o <= 1'b0;
            autovec_o <= 1'b0;
            rdata_o <= 32'h0;
            busy_o <= 1'b0;
            addr_o <= 32'h0;
            size_code_high_o <= 1'b0;
            size_code_low_o <= 1'b0;
            read_write_o <= 1'b1;
            native_data_strobe_n_o <= 1'b1;
            legacy_upper_byte_strobe_n_o <= 1'b1;
            legacy_lower_byte_strobe_n_o <= 1'b1;
            upper_byte_write_strobe_n_o <= 1'b1;
            lower_byte_write_strobe_n_o <= 1'b1;
            transfer_complete_strobe_n_o <= 1'b1;
            data_o <= 16'h0;
            data_oe_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            fault_o <= 1'b0;
            retry_o <= 1'b0;
            autovec_o <= 1'b0;
            transfer_complete_strobe_n_o <= 1'b1;
            case (state_reg)
                ST_IDLE: begin
                    // Operand captured whole; request may drop once busy
                    if (req_i) begin
                        state_reg <= ST_ADDR;
                        busy_o <= 1'b1;
                        size_reg <= req_size_i;
                        total_reg <= bytes_of(req_size_i);
                        op_reg <= req_wdata_i;
                        write_reg <= req_write_i;
                        iack_reg <= req_iack_i;
                        legacy_reg <= req_legacy_i;
                        extm_reg <= req_ext_master_i;
                        rdata_o <= 32'h0;
                        addr_o <= req_addr_i;
                        size_code_high_o <= req_size_i[1];
                        size_code_low_o <= req_size_i[0];
                    end
                end
                ST_ADDR: begin
                    state_reg <= ST_DATA;
                    wait_reg <= 4'h0;
                    mon_reg <= 8'h0;
                    read_write_o <= !write_reg;
                    if (write_reg) begin
                        // Both lanes driven; narrow port takes 15-8
                        data_oe_o <= 1'b1;
                        data_o <= addr_o[0] ?
                            {2{op_byte(op_reg, total_reg, idx)}} :
                            {op_byte(op_reg, total_reg, idx),
                             (left == 3'h1) ? op_byte(op_reg, total_reg, idx)
                             : op_byte(op_reg, total_reg, idx + 3'h1)};
                    end
                    // Enables switch on the edge of the strobes they follow
                    if (legacy_reg) begin
                        legacy_upper_byte_strobe_n_o <= addr_o[0];
                        legacy_lower_byte_strobe_n_o <=
                            !lower_lane(addr_o[0], left);
                        upper_byte_write_strobe_n_o <= !write_reg ||
                            addr_o[0];
                        lower_byte_write_strobe_n_o <= !write_reg ||
                            !lower_lane(addr_o[0], left);
                    end else begin
                        native_data_strobe_n_o <= 1'b0;
                        upper_byte_write_strobe_n_o <= !write_reg ||
                            addr_o[0];
                        lower_byte_write_strobe_n_o <= !write_reg ||
                            (!addr_o[0] && size_code_low_o);
                    end
                end
                ST_DATA: begin
                    // Counters saturate so a hung slave cannot wrap them
                    if (wait_reg != 4'hF) begin
                        wait_reg <= wait_reg + 4'h1;
                    end
                    if (mon_reg != MON_CYCLES) begin
                        mon_reg <= mon_reg + 8'h1;
                    end
                    if (ends) begin
                        state_reg <= ST_NEXT;
                        native_data_strobe_n_o <= 1'b1;
                        legacy_upper_byte_strobe_n_o <= 1'b1;
                        legacy_lower_byte_strobe_n_o <= 1'b1;
                        upper_byte_write_strobe_n_o <= 1'b1;
                        lower_byte_write_strobe_n_o <= 1'b1;
                        data_oe_o <= 1'b0;
                        // Completion strobe skipped on normal fault/retry
                        transfer_complete_strobe_n_o <=
                            code == `EBS_END_FAULT ||
                            code == `EBS_END_RETRY;
                        if (code == `EBS_END_FAULT ||
                            code == `EBS_END_LATE_FAULT) begin
                            fault_o <= 1'b1;
                            busy_o <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else if (code == `EBS_END_RETRY ||
                            code == `EBS_END_LATE_RETRY) begin
                            retry_o <= 1'b1;
                            busy_o <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else if (code == `EBS_END_AUTOVEC) begin
                            autovec_o <= 1'b1;
                            done_o <= 1'b1;
                            busy_o <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            if (!write_reg) begin
                                // Take only the requested lanes
                                if (moved == 3'h2) begin
                                    rdata_o <= {rdata_o[15:0], data_i};
                                end else if (wide && addr_o[0]) begin
                                    rdata_o <= {rdata_o[23:0], data_i[7:0]};
                                end else begin
                                    rdata_o <= {rdata_o[23:0],
                                        data_i[15:8]};
                                end
                            end
                            if (left_next == 3'h0) begin
                                done_o <= 1'b1;
                                busy_o <= 1'b0;
                                state_reg <= ST_IDLE;
                            end else begin
                                size_reg <= left_next[1:0];
                                size_code_high_o <= left_next[1];
                                size_code_low_o <= left_next[0];
                                addr_o <= addr_o + {29'h0, moved};
                            end
                        end
                    end
                end
                ST_NEXT: begin
                    // Gap clock lets the last ack drain from the synchroniser
                    state_reg <= busy_o ? ST_ADDR : ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // ebs_bus_master
`default_nettype wire

// ===== testbench/ebs_checker_assertions.sv
// Concurrent checks on the bus master pins
`default_nettype none
module ebs_checker (
    // Watched ports
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic req_iack_i,
    input wire logic late_term_i,
    input wire logic fault_o,
    input wire logic autovec_o,
    input wire logic busy_o,
    input wire logic data_oe_o,
    input wire logic [31:0] addr_o,
    input wire logic size_code_low_o,
    input wire logic read_write_o,
    input wire logic native_data_strobe_n_o,
    input wire logic legacy_upper_byte_strobe_n_o,
    input wire logic legacy_lower_byte_strobe_n_o,
    input wire logic upper_byte_write_strobe_n_o,
    input wire logic lower_byte_write_strobe_n_o,
    input wire logic transfer_complete_strobe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    upper_enable_a: assert property (
        !upper_byte_write_strobe_n_o |-> !read_write_o &&
        (!native_data_strobe_n_o && !addr_o[0] ||
        !legacy_upper_byte_strobe_n_o)) else $error("upper enable bad");
    lower_enable_a: assert property (
        !lower_byte_write_strobe_n_o |-> !read_write_o &&
        (!native_data_strobe_n_o && (addr_o[0] || !size_code_low_o) ||
        !legacy_lower_byte_strobe_n_o)) else $error("lower enable bad");
    upper_drive_a: assert property (!read_write_o &&
        !native_data_strobe_n_o && !addr_o[0] |->
        !upper_byte_write_strobe_n_o) else $error("upper enable missing");
    drive_marked_a: assert property (data_oe_o |->
        !upper_byte_write_strobe_n_o || !lower_byte_write_strobe_n_o)
        else $error("driven data unmarked");
    complete_pulse_a: assert property ($fell(transfer_complete_strobe_n_o)
        |=> transfer_complete_strobe_n_o) else $error("complete too long");
    fault_quiet_a: assert property (fault_o && !late_term_i |->
        transfer_complete_strobe_n_o && $past(transfer_complete_strobe_n_o))
        else $error("complete on fault");
    autovec_iack_a: assert property (autovec_o |-> req_iack_i)
        else $error("autovector outside iack");
    busy_start_a: assert property ($rose(busy_o) |-> $past(req_i))
        else $error("busy without request");
    addr_step_a: assert property (busy_o && $past(busy_o, 2) &&
        addr_o != $past(addr_o) |-> (addr_o - $past(addr_o)) inside {32'h1,
        32'h2}) else $error("address step bad");
endmodule // ebs_checker
`default_nettype wire

// ===== testbench/ebs_slave_model.sv
// Slave port model: 8 or 16 bit memory with selectable termination
`default_nettype none
module ebs_slave_model (
    // Clock, reset and scenario control
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wide_i,
    input wire logic [2:0] mode_i,
    input wire logic [3:0] wait_i,
    // Bus side
    input wire logic [31:0] addr_i,
    input wire logic rw_i,
    input wire logic strb_n_i,
    input wire logic uw_n_i,
    input wire logic lw_n_i,
    input wire logic [15:0] dat_i,
    output wire logic wa_n_o,
    output wire logic na_n_o,
    output wire logic bf_n_o,
    output wire logic hl_n_o,
    output wire logic av_n_o,
    output var logic [15:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:63];
    logic [3:0] cnt;
    wire [5:0] a = addr_i[5:0];
    // Acks drop with the strobe so a stale ack never ends the next cycle
    wire go = !strb_n_i && cnt > wait_i;
    wire ok = mode_i == 3'h0 || mode_i == 3'h4 || mode_i == 3'h6;
    // Mode 6 raises both acks: the reserved code, taken as wide
    assign wa_n_o = !(go && ok && (wide_i || mode_i == 3'h6));
    assign na_n_o = !(go && ok && (!wide_i || mode_i == 3'h6));
    assign bf_n_o = !(go && (mode_i == 3'h1 || mode_i == 3'h2));
    assign hl_n_o = !(go && mode_i == 3'h2);
    assign av_n_o = !(go && (mode_i == 3'h3 || mode_i == 3'h4));
    initial for (int i = 0; i < 64; i++) mem[i] = 8'((i * 37 + 5) & 255);
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 4'h0;
            dat_o <= 16'h5A5A;
        end else begin
            cnt <= strb_n_i ? 4'h0 : cnt + 4'(cnt != 4'hF);
            // Idle lanes toggle so a stale value cannot pass for data
            dat_o <= ~dat_o;
            if (!strb_n_i && rw_i) dat_o <= wide_i ? {mem[a & 6'h3E],
                mem[a | 6'h01]} : {mem[a], ~dat_o[7:0]};
            if (!strb_n_i && !rw_i && cnt == wait_i) begin
                if (!wide_i) mem[a] <= dat_i[15:8];
                if (wide_i && !uw_n_i) mem[a & 6'h3E] <= dat_i[15:8];
                if (wide_i && !lw_n_i) mem[a | 6'h01] <= dat_i[7:0];
            end
        end
    end
endmodule // ebs_slave_model
`default_nettype wire

// ===== testbench/external_bus_sizing_termination_tb.sv
// Self-checking bench for the external bus sizing and termination block
`default_nettype none
module external_bus_sizing_termination_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, nrst_i = 0, req_i = 0, w_r = 0, iack = 0, leg = 0;
    logic ia = 0, ft = 0, late = 0, wide = 1, st = 1, em = 0, sawtc;
    logic [1:0] sz_r = 2'h0, fsz, z;
    logic [2:0] md = 3'h0;
    logic [3:0] dly = 4'h3, oc;
    logic [31:0] a_r = 0, wd_r = 0, rd, ad, exp, a;
    logic [15:0] di, dq;
    logic dn, fl, rt, av, bz, sh, sl, rw, ds, lu, ll, uw, lw, tc, oe;
    logic wa_n, na_n, bf_n, hl_n, av_n;
    integer error_cnt = 0, check_count = 0, seed = 8, mem [0:63];
    integer n, ncyc, j, q, lat;
    ebs_bus_master #(.MON_CYCLES(8'h08)) u_dut (.clk_i(clk_i),
        .nrst_i(nrst_i), .req_i(req_i), .req_write_i(w_r), .req_size_i(sz_r),
        .req_addr_i(a_r), .req_wdata_i(wd_r), .req_iack_i(iack),
        .req_legacy_i(leg), .req_ext_master_i(em),
        .cfg_internal_ack_i(ia), .cfg_ack_delay_i(dly), .cfg_fast_term_i(ft),
        .done_o(dn), .fault_o(fl), .retry_o(rt), .autovec_o(av),
        .rdata_o(rd), .busy_o(bz), .wide_port_ack_n_i(wa_n),
        .narrow_port_ack_n_i(na_n), .bus_fault_input_n_i(bf_n),
        .halt_n_i(hl_n), .auto_vector_input_n_i(av_n), .late_term_i(late),
        .data_i(di), .addr_o(ad), .size_code_high_o(sh), .size_code_low_o(sl),
        .read_write_o(rw), .native_data_strobe_n_o(ds),
        .legacy_upper_byte_strobe_n_o(lu), .legacy_lower_byte_strobe_n_o(ll),
        .upper_byte_write_strobe_n_o(uw), .lower_byte_write_strobe_n_o(lw),
        .transfer_complete_strobe_n_o(tc), .data_o(dq), .data_oe_o(oe));
    ebs_slave_model u_slv (.clk_i(clk_i), .nrst_i(nrst_i), .wide_i(wide),
        .mode_i(md), .wait_i(4'h1), .addr_i(ad), .rw_i(rw),
        .strb_n_i(ds & lu & ll), .uw_n_i(uw), .lw_n_i(lw), .dat_i(dq),
        .wa_n_o(wa_n), .na_n_o(na_n), .bf_n_o(bf_n), .hl_n_o(hl_n),
        .av_n_o(av_n), .dat_o(di));
    initial forever #4 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] e, input logic [31:0] s,
        input string nm);
        check_count++;
        if (e !== s) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic op(input logic w, input logic [2:0] m, input logic [3:0] e);
        @(posedge clk_i);
        #1;
        n = z ? z : 4;
        w_r = w;
        sz_r = z;
        a_r = a;
        wd_r = $random(seed) & (32'hFFFFFFFF >> (32 - 8 * n));
        md = m;
        req_i = 1;
        @(posedge clk_i);
        #1;
        req_i = 0;
        ncyc = 0;
        lat = 0;
        sawtc = 0;
        oc = 0;
        while (oc == 0 && lat < 300) begin
            @(posedge clk_i);
            #1;
            lat++;
            if (st && !(ds & lu & ll) && ncyc == 0) fsz = {sh, sl};
            if (st && !(ds & lu & ll)) ncyc++;
            st = ds & lu & ll;
            if (tc === 1'b0) sawtc = 1;
            oc = {dn === 1'b1, fl === 1'b1, rt === 1'b1, av === 1'b1};
        end
        chk(e, oc, "outcome");
        if (e == 4'h8) begin
            chk(1, sawtc, "complete");
            chk(z, fsz, "first size");
            chk(wide ? (n + 1) / 2 : n, ncyc, "cycles");
            exp = 0;
            for (q = 0; q < n; q++) begin
                if (w) mem[a + q] = wd_r[8 * (n - 1 - q) +: 8];
                exp = exp << 8 | mem[a + q];
            end
            if (!w) chk(exp, rd, "read data");
        end
    endtask
    initial begin
        for (j = 0; j < 64; j++) mem[j] = (j * 37 + 5) & 255;
        #69;
        nrst_i = 1;
        // Byte, word and long on both port widths with native strobes, then word and long with legacy strobes
        for (j = 0; j < 12; j++) begin
            wide = j[0];
            leg = j[3];
            z = 2'(((j / 2) % 3 + 1) % 3);
            a = ($random(seed) & 32'h38) | (z == 1 ? $random(seed) & 1 : 0);
            op(1, 3'h0, 4'h8);
            op(0, 3'h0, 4'h8);
        end
        wide = 0;
        leg = 0;
        z = 2'h0;
        a = 32'h8;
        op(0, 3'h1, 4'h4);
        chk(1, ncyc, "fault cycles");
        chk(0, sawtc, "fault complete");
        op(0, 3'h2, 4'h2);
        z = 2'h1;
        late = 1;
        op(0, 3'h1, 4'h4);
        chk(1, sawtc, "late complete");
        op(0, 3'h2, 4'h2);
        chk(1, sawtc, "late retry complete");
        // Hold late flag and iack past the edge that samples the pulse
        @(posedge clk_i);
        #1;
        late = 0;
        iack = 1;
        op(0, 3'h3, 4'h9);
        @(posedge clk_i);
        #1;
        iack = 0;
        op(0, 3'h4, 4'h8);
        wide = 1;
        z = 2'h0;
        op(0, 3'h6, 4'h8);
        wide = 0;
        z = 2'h1;
        ia = 1;
        a = 32'h9;
        op(0, 3'h5, 4'h8);
        dly = 4'hF;
        op(0, 3'h0, 4'h8);
        chk(1, lat < 14, "early end");
        ia = 0;
        ft = 1;
        op(1, 3'h5, 4'h8);
        ft = 0;
        op(0, 3'h5, 4'h4);
        em = 1;
        ia = 1;
        op(0, 3'h5, 4'h8);
        give_verdict;
    end
    initial begin
        #200000;
        error_cnt++;
        give_verdict;
    end
endmodule // external_bus_sizing_termination_tb
bind ebs_bus_master ebs_checker u_chk (.clk_i, .nrst_i, .req_i, .req_iack_i,
    .late_term_i, .fault_o, .autovec_o, .busy_o, .addr_o, .size_code_low_o,
    .read_write_o, .native_data_strobe_n_o, .legacy_upper_byte_strobe_n_o,
    .legacy_lower_byte_strobe_n_o, .upper_byte_write_strobe_n_o,
    .lower_byte_write_strobe_n_o, .transfer_complete_strobe_n_o, .data_oe_o);
`default_nettype wire
